/* ddsp_ctrl_model.sv */
// external controller model driving the profile and serial ramp lines
`timescale 1ns/10ps
module ddsp_ctrl_model (
	input wire logic clk,
	output ddsp_pkg::ddsp_pins_s pins
);
	// ****************************************
	// pin drive
	// ****************************************
	// pins are push-pull outputs of the controller, never released
	initial begin
		pins = '0;
	end

	// pin 1 edges drive sweep start and direction
	task automatic set_profile(input logic [3:0] v);
		@(negedge clk);
		pins.profile = v;
	endtask : set_profile

	// ramp requests on the serial lines
	task automatic set_sdio(input logic [3:1] v);
		@(negedge clk);
		pins.sdio = v;
	endtask : set_sdio
endmodule : ddsp_ctrl_model

/* ddsp_pin_sync.sv */
// two-flop synchroniser for the profile and serial line pins
`timescale 1ns/10ps
module ddsp_pin_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire ddsp_pkg::ddsp_pins_s pins_in,
	output ddsp_pkg::ddsp_pins_s pins_out
);
	localparam int W = $bits(ddsp_pkg::ddsp_pins_s);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// meta_r feeds only sync_r
	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= pins_in[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	assign pins_out = sync_r;
endmodule : ddsp_pin_sync

/* ddsp_pkg.sv */
// constants and types shared by the sweep and profile control block
package ddsp_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] ADDR_FR1 = 8'h01;
	localparam logic [7:0] ADDR_CFR = 8'h03;
	localparam logic [7:0] ADDR_P0_FREQ = 8'h04;
	localparam logic [7:0] ADDR_P0_PHASE = 8'h05;
	localparam logic [7:0] ADDR_P0_AMP = 8'h06;
	localparam logic [7:0] ADDR_RATES = 8'h07;
	localparam logic [7:0] ADDR_RISE_STEP = 8'h08;
	localparam logic [7:0] ADDR_FALL_STEP = 8'h09;
	localparam logic [7:0] ADDR_P1 = 8'h0A;
	localparam logic [7:0] ADDR_P3 = 8'h0C;
	localparam logic [7:0] ADDR_P13 = 8'h16;
	localparam logic [7:0] ADDR_STATUS = 8'h1F;

	localparam int NREG = 11;
	localparam int IDX_FR1 = 0;
	localparam int IDX_CFR = 1;
	localparam int IDX_P0_FREQ = 2;
	localparam int IDX_P0_PHASE = 3;
	localparam int IDX_P0_AMP = 4;
	localparam int IDX_RATES = 5;
	localparam int IDX_RISE_STEP = 6;
	localparam int IDX_FALL_STEP = 7;
	localparam int IDX_P1 = 8;
	localparam logic [7:0] REG_ADDR [NREG] = '{ADDR_FR1, ADDR_CFR,
		ADDR_P0_FREQ, ADDR_P0_PHASE, ADDR_P0_AMP, ADDR_RATES,
		ADDR_RISE_STEP, ADDR_FALL_STEP, ADDR_P1, ADDR_P3, ADDR_P13};
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// ****************************************
	// field positions and widths
	// ****************************************
	localparam int CFR_TGT_LSB = 22;
	localparam int CFR_NO_DWELL = 15;
	localparam int CFR_SWEEP_EN = 14;
	localparam int FR1_PPC_LSB = 12;
	localparam int FR1_RAMP_LSB = 10;
	localparam int FR1_LEVEL_LSB = 8;
	localparam int RATE_RISE_LSB = 0;
	localparam int RATE_FALL_LSB = 8;
	localparam int PHASE_SHIFT = 18;
	localparam int AMP_SHIFT = 22;
	localparam logic [31:0] PHASE_MASK = 32'hFFFC_0000;
	localparam logic [31:0] AMP_MASK = 32'hFFC0_0000;
	localparam logic [7:0] PERIOD_MIN = 8'h01;
	localparam logic [2:0] PPC_LOW = 3'h0;
	localparam logic [2:0] PPC_HIGH = 3'h3;
	localparam logic [1:0] PPC_ANY_01 = 2'h1;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {TGT_NONE = 2'h0, TGT_AMP = 2'h1,
		TGT_FREQ = 2'h2, TGT_PHASE = 2'h3} ddsp_target_e;
	typedef enum logic [1:0] {LVL_2 = 2'h0, LVL_4 = 2'h1,
		LVL_8 = 2'h2, LVL_16 = 2'h3} ddsp_level_e;
	typedef enum logic [1:0] {RAMP_OFF = 2'h0, RAMP_P23 = 2'h1,
		RAMP_P3 = 2'h2, RAMP_SDIO = 2'h3} ddsp_ramp_e;
	typedef enum logic [1:0] {ST_START, ST_RISE, ST_END, ST_FALL}
		ddsp_state_e;

	typedef struct packed {
		logic wr_en;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ddsp_bus_s;

	typedef struct packed {
		logic [3:0] profile;
		logic [3:1] sdio;
	} ddsp_pins_s;

endpackage : ddsp_pkg

/* ddsp_rate_timer.sv */
// loadable 8-bit down counter that paces sweep steps
`timescale 1ns/10ps
module ddsp_rate_timer (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic run,
	input wire logic [7:0] period,
	output logic step
);
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] per;

	// zero period would stall forever, treat as one
	always_comb begin
		per = (period == 8'h00) ? ddsp_pkg::PERIOD_MIN : period;
		cnt_nxt = cnt_r;
		step = 1'b0;
		if (load) begin
			cnt_nxt = per;
		end else if (run) begin
			if (cnt_r <= ddsp_pkg::PERIOD_MIN) begin
				step = 1'b1;
				cnt_nxt = per;
			end else begin
				cnt_nxt = cnt_r - ddsp_pkg::PERIOD_MIN;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			cnt_r <= ddsp_pkg::PERIOD_MIN;
		else
			cnt_r <= cnt_nxt;
	end
endmodule : ddsp_rate_timer

/* ddsp_tb_top.sv */
// self-checking testbench for the sweep and profile control block
`timescale 1ns/10ps
module ddsp_tb_top;
	logic clk;
	logic rst_b;
	ddsp_pkg::ddsp_bus_s bus;
	ddsp_pkg::ddsp_pins_s pins;
	logic [31:0] reg_rdata_r;
	logic [3:0] profile_index_r;
	logic [31:0] sweep_word_r;
	ddsp_pkg::ddsp_target_e sweep_target_r;
	logic sweep_busy_r;
	logic amplitude_ramp_control_r;
	logic ramp_enable_r;
	logic serial_single_line_r;
	int err_count;
	int total_checks;
	int n;
	logic [31:0] rv;
	logic [7:0] regs [9] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h0A, 8'h0C, 8'h16};

	ddsp_top u_dut (
		.clk(clk),
		.rst_b(rst_b),
		.bus(bus),
		.pins(pins),
		.reg_rdata_r(reg_rdata_r),
		.profile_index_r(profile_index_r),
		.sweep_word_r(sweep_word_r),
		.sweep_target_r(sweep_target_r),
		.sweep_busy_r(sweep_busy_r),
		.amplitude_ramp_control_r(amplitude_ramp_control_r),
		.ramp_enable_r(ramp_enable_r),
		.serial_single_line_r(serial_single_line_r)
	);

	ddsp_ctrl_model u_ctrl (
		.clk(clk),
		.pins(pins)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clk);
		bus = '{1'b1, a, d};
		@(negedge clk);
		bus.wr_en = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(negedge clk);
		bus.addr = a;
		@(negedge clk);
		d = reg_rdata_r;
	endtask : rd

	// bounded wait, counts negedges until busy reaches v
	task automatic wait_busy(input logic v, output int cnt);
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while (sweep_busy_r !== v && cnt < 40);
	endtask : wait_busy

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// watchdog, the whole sequence needs well under 1000 cycles
	initial begin
		#80000;
		err_count++;
		wrap_up();
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		bus = '0;
		rst_b = 1'b0;
		err_count = 0;
		total_checks = 0;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		// registers: reset value, write, readback, unmapped
		foreach (regs[i]) begin
			rd(regs[i], rv);
			check("reset value", rv, 32'h0000_0000);
			wr(regs[i], {8'hA5, 16'h3C00, regs[i]});
		end
		foreach (regs[i]) begin
			rd(regs[i], rv);
			check("readback", rv, {8'hA5, 16'h3C00, regs[i]});
		end
		wr(8'hE4, 32'hFFFF_FFFF);
		rd(8'hE4, rv);
		check("unmapped", rv, 32'h0000_0000);
		// four-level keying, ppc 011, serial ramp field 11
		wr(ddsp_pkg::ADDR_FR1, 32'h0000_3D00);
		u_ctrl.set_profile(4'b0011);
		u_ctrl.set_sdio(3'b001);
		repeat (5) @(negedge clk);
		check("index p0p1", profile_index_r, 4'h3);
		check("ramp up sdio1", amplitude_ramp_control_r, 1'b1);
		check("single line", serial_single_line_r, 1'b1);
		check("ramp enable", ramp_enable_r, 1'b1);
		// ppc 000 uses pins 2 and 3, ramp on serial line 2
		wr(ddsp_pkg::ADDR_FR1, 32'h0000_0D00);
		u_ctrl.set_profile(4'b0100);
		u_ctrl.set_sdio(3'b010);
		repeat (5) @(negedge clk);
		check("index p2p3", profile_index_r, 4'h2);
		check("sdio2 high", amplitude_ramp_control_r, 1'b1);
		u_ctrl.set_sdio(3'b101);
		repeat (5) @(negedge clk);
		check("sdio2 low", amplitude_ramp_control_r, 1'b0);
		// sixteen-level, ppc x01 given as 101, pins 1101
		wr(ddsp_pkg::ADDR_FR1, 32'h0000_5F00);
		u_ctrl.set_profile(4'b1011);
		repeat (5) @(negedge clk);
		check("index 16 level", profile_index_r, 4'hD);
		check("ramp sdio1", amplitude_ramp_control_r, 1'b1);
		// profile pin ramp, field 10 uses pin 3, low means up
		wr(ddsp_pkg::ADDR_FR1, 32'h0000_0A00);
		u_ctrl.set_profile(4'b1000);
		repeat (5) @(negedge clk);
		check("pin ramp down", amplitude_ramp_control_r, 1'b0);
		check("no single line", serial_single_line_r, 1'b0);
		u_ctrl.set_profile(4'b0000);
		repeat (5) @(negedge clk);
		check("pin ramp up", amplitude_ramp_control_r, 1'b1);
		// frequency sweep; two-level, steps kept below full-scale
		wr(ddsp_pkg::ADDR_FR1, 32'h0000_0000);
		wr(ddsp_pkg::ADDR_P0_FREQ, 32'h0000_0064);
		wr(ddsp_pkg::ADDR_P1, 32'h0000_0100);
		wr(ddsp_pkg::ADDR_RISE_STEP, 32'h0000_0040);
		wr(ddsp_pkg::ADDR_FALL_STEP, 32'h0000_0030);
		wr(ddsp_pkg::ADDR_RATES, 32'h0000_0302);
		wr(ddsp_pkg::ADDR_CFR, 32'h0080_4000);
		u_ctrl.set_profile(4'b0010);
		wait_busy(1'b1, n);
		check("freq target", sweep_target_r, ddsp_pkg::TGT_FREQ);
		wait_busy(1'b0, n);
		// three rising steps of two cycles, clamped at end
		check("rise cycles", n, 6);
		check("end value", sweep_word_r, 32'h0000_0100);
		repeat (6) @(negedge clk);
		check("dwell at end", sweep_word_r, 32'h0000_0100);
		rd(ddsp_pkg::ADDR_STATUS, rv);
		check("status", rv, 32'h0000_0041);
		check("ramp off", ramp_enable_r, 1'b0);
		u_ctrl.set_profile(4'b0000);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		// four falling steps of three cycles
		check("fall cycles", n, 12);
		check("start value", sweep_word_r, 32'h0000_0064);
		// no-dwell: back to start after reaching end
		wr(ddsp_pkg::ADDR_CFR, 32'h0080_C000);
		u_ctrl.set_profile(4'b0010);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		check("no dwell cycles", n, 6);
		check("no dwell revert", sweep_word_r, 32'h0000_0064);
		u_ctrl.set_profile(4'b0000);
		repeat (10) @(negedge clk);
		check("fall ignored", sweep_busy_r, 1'b0);
		check("fall word", sweep_word_r, 32'h0000_0064);
		// select 00 with enable gives no sweep
		wr(ddsp_pkg::ADDR_CFR, 32'h0000_4000);
		u_ctrl.set_profile(4'b0010);
		repeat (10) @(negedge clk);
		check("no target", sweep_busy_r, 1'b0);
		u_ctrl.set_profile(4'b0000);
		// amplitude sweep, end and step msb-aligned with junk low bits
		wr(ddsp_pkg::ADDR_P0_AMP, 32'h0000_0010);
		wr(ddsp_pkg::ADDR_P1, 32'h0800_FFFF);
		wr(ddsp_pkg::ADDR_RISE_STEP, 32'h0200_00FF);
		wr(ddsp_pkg::ADDR_RATES, 32'h0000_0101);
		wr(ddsp_pkg::ADDR_CFR, 32'h0040_4000);
		u_ctrl.set_profile(4'b0010);
		wait_busy(1'b1, n);
		check("amp target", sweep_target_r, ddsp_pkg::TGT_AMP);
		wait_busy(1'b0, n);
		check("amp cycles", n, 2);
		check("amp end", sweep_word_r, 32'h0800_0000);
		// phase sweep, start from low bits of the phase word
		wr(ddsp_pkg::ADDR_CFR, 32'h0000_0000);
		u_ctrl.set_profile(4'b0000);
		wr(ddsp_pkg::ADDR_P0_PHASE, 32'h0000_0100);
		wr(ddsp_pkg::ADDR_P1, 32'h0C00_3FFF);
		wr(ddsp_pkg::ADDR_RISE_STEP, 32'h0400_1234);
		wr(ddsp_pkg::ADDR_CFR, 32'h00C0_4000);
		u_ctrl.set_profile(4'b0010);
		check("phase start", sweep_word_r, 32'h0400_0000);
		wait_busy(1'b1, n);
		check("phase target", sweep_target_r, ddsp_pkg::TGT_PHASE);
		wait_busy(1'b0, n);
		check("phase cycles", n, 2);
		check("phase end", sweep_word_r, 32'h0C00_0000);
		wrap_up();
	end
endmodule : ddsp_tb_top

/* ddsp_top.sv */
// sweep and profile control: registers, keying select, sweep engine
// Operation
// - four-level with serial ramp: ppc 011 uses pins 0,1; 000 pins 2,3
// - sixteen-level ppc x01: profile from pins 0-3, ramp on serial line 1
// - sweep starts at profile 0 word of swept quantity, ends at profile 1
// - end value 32/14/10 bits, phase and amplitude msb-aligned in profile 1
// - edges of profile pin 1 trigger sweep and set its direction
// - with sweep enabled, select 01 amp, 10 freq, 11 phase, 00 none
// - rising words for upward sweeps, falling words for downward
// - ramp periods 8 bits; steps 32, 14 or 10 bits
// - each step lasts the active ramp period in clock cycles
// - each upward step but the last adds the rising step word to the accumulator, each downward step but the last subtracts the falling one
// - accumulator overflow sweeps on uncontrolled; controller avoids it
// - pin rising edge selects rising step word and loads rising period
// - upward sweep stops at end value and holds it
// - pin falling edge runs falling step down to start and holds it
// - without no-dwell, direction and end state follow profile pin 1
// - with no-dwell, accumulator clears once upward sweep reaches end
// - no-dwell: pin high sweeps up, then rests at start until next high
// - no-dwell ignores the falling step word and falling period
// - step words and periods may change mid-sweep, used by later steps
// - amplitude ramp control from profile or serial lines per config
// - ramp field 11 gives serial lines to ramp, serial port one line
// - profile pin ramp control: low requests up, high requests down
`timescale 1ns/10ps
module ddsp_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire ddsp_pkg::ddsp_bus_s bus,
	input wire ddsp_pkg::ddsp_pins_s pins,
	output logic [31:0] reg_rdata_r,
	output logic [3:0] profile_index_r,
	output logic [31:0] sweep_word_r,
	output ddsp_pkg::ddsp_target_e sweep_target_r,
	output logic sweep_busy_r,
	output logic amplitude_ramp_control_r,
	output logic ramp_enable_r,
	output logic serial_single_line_r
);

	// ****************************************
	// register file
	// ****************************************
	logic [31:0] regs_r [ddsp_pkg::NREG];
	logic [31:0] regs_nxt [ddsp_pkg::NREG];
	logic [31:0] rdata_nxt;

	always_comb begin
		for (int i = 0; i < ddsp_pkg::NREG; i++) begin
			regs_nxt[i] = regs_r[i];
			if (bus.wr_en && bus.addr == ddsp_pkg::REG_ADDR[i])
				regs_nxt[i] = bus.wdata;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < ddsp_pkg::NREG; i++) begin
			if (!rst_b)
				regs_r[i] <= ddsp_pkg::REG_RESET;
			else
				regs_r[i] <= regs_nxt[i];
		end
	end

	// ****************************************
	// configuration fields
	// ****************************************
	logic [31:0] channel_function_reg;
	logic [31:0] fr1;
	ddsp_pkg::ddsp_target_e target;
	ddsp_pkg::ddsp_level_e level;
	ddsp_pkg::ddsp_ramp_e ramp;
	logic [2:0] pin_assign_config;
	logic no_dwell;
	logic active;
	logic [7:0] rise_per;
	logic [7:0] fall_per;

	assign channel_function_reg = regs_r[ddsp_pkg::IDX_CFR];
	assign fr1 = regs_r[ddsp_pkg::IDX_FR1];
	assign target = ddsp_pkg::ddsp_target_e'(channel_function_reg[ddsp_pkg::CFR_TGT_LSB +: 2]);
	assign level = ddsp_pkg::ddsp_level_e'(fr1[ddsp_pkg::FR1_LEVEL_LSB +: 2]);
	assign ramp = ddsp_pkg::ddsp_ramp_e'(fr1[ddsp_pkg::FR1_RAMP_LSB +: 2]);
	assign pin_assign_config = fr1[ddsp_pkg::FR1_PPC_LSB +: 3];
	assign no_dwell = channel_function_reg[ddsp_pkg::CFR_NO_DWELL];
	assign active = channel_function_reg[ddsp_pkg::CFR_SWEEP_EN] &&
		(target != ddsp_pkg::TGT_NONE);
	assign rise_per = regs_r[ddsp_pkg::IDX_RATES][ddsp_pkg::RATE_RISE_LSB +: 8];
	assign fall_per = regs_r[ddsp_pkg::IDX_RATES][ddsp_pkg::RATE_FALL_LSB +: 8];

	// ****************************************
	// pin sampling
	// ****************************************
	ddsp_pkg::ddsp_pins_s pin_s;
	logic p1_prev_r;
	logic p1_rise;
	logic p1_fall;

	ddsp_pin_sync u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.pins_in(pins),
		.pins_out(pin_s)
	);

	assign p1_rise = pin_s.profile[1] && !p1_prev_r;
	assign p1_fall = !pin_s.profile[1] && p1_prev_r;

	// ****************************************
	// keying select and amplitude ramp
	// ****************************************
	logic [3:0] index_nxt;
	logic ramp_up_nxt;
	logic ramp_en_nxt;
	logic single_nxt;
	logic [3:0] pp;

	assign pp = pin_s.profile;

	always_comb begin
		index_nxt = {3'h0, pp[1]};
		if (level == ddsp_pkg::LVL_4) begin
			if (ramp == ddsp_pkg::RAMP_SDIO && pin_assign_config == ddsp_pkg::PPC_LOW)
				index_nxt = {2'h0, pp[2], pp[3]};
			else if (pin_assign_config == ddsp_pkg::PPC_HIGH)
				index_nxt = {2'h0, pp[0], pp[1]};
		end else if (pin_assign_config[1:0] == ddsp_pkg::PPC_ANY_01) begin
			if (level == ddsp_pkg::LVL_16)
				index_nxt = {pp[0], pp[1], pp[2], pp[3]};
			else if (level == ddsp_pkg::LVL_8)
				index_nxt = {1'b0, pp[0], pp[1], pp[2]};
		end
	end

	always_comb begin
		ramp_en_nxt = (ramp != ddsp_pkg::RAMP_OFF);
		single_nxt = (ramp == ddsp_pkg::RAMP_SDIO);
		unique case (ramp)
			ddsp_pkg::RAMP_OFF: ramp_up_nxt = 1'b0;
			ddsp_pkg::RAMP_P23:
				ramp_up_nxt = (pin_assign_config == ddsp_pkg::PPC_LOW) ? !pp[3] : !pp[2];
			ddsp_pkg::RAMP_P3: ramp_up_nxt = !pp[3];
			// line 2 for four-level ppc 000, else line 1
			ddsp_pkg::RAMP_SDIO:
				ramp_up_nxt = (level == ddsp_pkg::LVL_4 &&
					pin_assign_config == ddsp_pkg::PPC_LOW) ? pin_s.sdio[2] : pin_s.sdio[1];
		endcase
	end

	// ****************************************
	// sweep datapath
	// ****************************************
	logic [31:0] start_al;
	logic [31:0] end_al;
	logic [31:0] rdw_al;
	logic [31:0] fdw_al;
	logic [31:0] cur;
	logic [32:0] up_sum;
	logic [32:0] dn_lim;
	logic up_done;
	logic dn_done;

	// narrow words keep only their top bits
	function automatic logic [31:0] msb_align(input logic [31:0] w,
		input ddsp_pkg::ddsp_target_e t);
		msb_align = w;
		if (t == ddsp_pkg::TGT_PHASE)
			msb_align = w & ddsp_pkg::PHASE_MASK;
		else if (t == ddsp_pkg::TGT_AMP)
			msb_align = w & ddsp_pkg::AMP_MASK;
	endfunction : msb_align

	// start from the matching profile 0 word
	always_comb begin
		unique case (target)
			ddsp_pkg::TGT_PHASE:
				start_al = regs_r[ddsp_pkg::IDX_P0_PHASE] << ddsp_pkg::PHASE_SHIFT;
			ddsp_pkg::TGT_AMP:
				start_al = regs_r[ddsp_pkg::IDX_P0_AMP] << ddsp_pkg::AMP_SHIFT;
			ddsp_pkg::TGT_FREQ, ddsp_pkg::TGT_NONE:
				start_al = regs_r[ddsp_pkg::IDX_P0_FREQ];
		endcase
	end

	// end value msb-aligned in profile 1
	assign end_al = msb_align(regs_r[ddsp_pkg::IDX_P1], target);
	assign rdw_al = msb_align(regs_r[ddsp_pkg::IDX_RISE_STEP], target);
	assign fdw_al = msb_align(regs_r[ddsp_pkg::IDX_FALL_STEP], target);

	// ****************************************
	// sweep engine
	// ****************************************
	ddsp_pkg::ddsp_state_e state_r;
	ddsp_pkg::ddsp_state_e state_nxt;
	logic [31:0] acc_r;
	logic [31:0] acc_nxt;
	logic tmr_load;
	logic tmr_run;
	logic [7:0] tmr_period;
	logic step;

	assign cur = start_al + acc_r;
	assign up_sum = {1'b0, cur} + {1'b0, rdw_al};
	assign dn_lim = {1'b0, start_al} + {1'b0, fdw_al};
	// a carry out never counts as reaching the end
	assign up_done = !up_sum[32] && (up_sum[31:0] >= end_al);
	assign dn_done = ({1'b0, cur} <= dn_lim);

	assign tmr_run = active && (state_r == ddsp_pkg::ST_RISE ||
		state_r == ddsp_pkg::ST_FALL);
	assign tmr_period = (!no_dwell && (p1_fall ||
		(state_r == ddsp_pkg::ST_FALL && !p1_rise))) ? fall_per : rise_per;

	ddsp_rate_timer u_timer (
		.clk(clk),
		.rst_b(rst_b),
		.load(tmr_load),
		.run(tmr_run),
		.period(tmr_period),
		.step(step)
	);

	always_comb begin
		state_nxt = state_r;
		acc_nxt = acc_r;
		tmr_load = 1'b0;
		if (!active) begin
			state_nxt = ddsp_pkg::ST_START;
			acc_nxt = '0;
		end else if (no_dwell) begin
			unique case (state_r)
				// wait at start for the pin
				ddsp_pkg::ST_START: begin
					if (p1_rise) begin
						state_nxt = ddsp_pkg::ST_RISE;
						tmr_load = 1'b1;
					end
				end
				ddsp_pkg::ST_RISE: begin
					if (step && up_done) begin
						acc_nxt = '0;
						state_nxt = ddsp_pkg::ST_START;
					end else if (step) begin
						acc_nxt = acc_r + rdw_al;
					end
				end
				ddsp_pkg::ST_END, ddsp_pkg::ST_FALL: begin
					acc_nxt = '0;
					state_nxt = ddsp_pkg::ST_START;
				end
			endcase
		end else if (p1_rise) begin
			state_nxt = ddsp_pkg::ST_RISE;
			tmr_load = 1'b1;
		end else if (p1_fall) begin
			state_nxt = ddsp_pkg::ST_FALL;
			tmr_load = 1'b1;
		end else begin
			unique case (state_r)
				ddsp_pkg::ST_RISE: begin
					if (step && up_done) begin
						acc_nxt = end_al - start_al;
						state_nxt = ddsp_pkg::ST_END;
					end else if (step) begin
						acc_nxt = acc_r + rdw_al;
					end
				end
				ddsp_pkg::ST_FALL: begin
					if (step && dn_done) begin
						acc_nxt = '0;
						state_nxt = ddsp_pkg::ST_START;
					end else if (step) begin
						acc_nxt = acc_r - fdw_al;
					end
				end
				ddsp_pkg::ST_START, ddsp_pkg::ST_END: ;
			endcase
		end
	end

	// ****************************************
	// registered state and outputs
	// ****************************************
	always_comb begin
		rdata_nxt = ddsp_pkg::REG_RESET;
		for (int i = 0; i < ddsp_pkg::NREG; i++)
			if (bus.addr == ddsp_pkg::REG_ADDR[i])
				rdata_nxt = regs_r[i];
		if (bus.addr == ddsp_pkg::ADDR_STATUS)
			rdata_nxt = {25'h0000000, state_r, sweep_busy_r, profile_index_r};
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= ddsp_pkg::ST_START;
			acc_r <= ddsp_pkg::REG_RESET;
			p1_prev_r <= 1'b0;
			reg_rdata_r <= ddsp_pkg::REG_RESET;
			profile_index_r <= 4'h0;
			sweep_word_r <= ddsp_pkg::REG_RESET;
			sweep_target_r <= ddsp_pkg::TGT_NONE;
			sweep_busy_r <= 1'b0;
			amplitude_ramp_control_r <= 1'b0;
			ramp_enable_r <= 1'b0;
			serial_single_line_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			acc_r <= acc_nxt;
			p1_prev_r <= pin_s.profile[1];
			reg_rdata_r <= rdata_nxt;
			profile_index_r <= index_nxt;
			sweep_word_r <= start_al + acc_nxt;
			sweep_target_r <= active ? target : ddsp_pkg::TGT_NONE;
			sweep_busy_r <= (state_nxt == ddsp_pkg::ST_RISE ||
				state_nxt == ddsp_pkg::ST_FALL);
			amplitude_ramp_control_r <= ramp_up_nxt;
			ramp_enable_r <= ramp_en_nxt;
			serial_single_line_r <= single_nxt;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_rise_edge;
		active && !no_dwell && p1_rise |=> state_r == ddsp_pkg::ST_RISE;
	endproperty
	a_rise_edge: assert property (p_rise_edge)
		else $error("rising edge did not start upward sweep");

	property p_fall_edge;
		active && !no_dwell && p1_fall |=> state_r == ddsp_pkg::ST_FALL;
	endproperty
	a_fall_edge: assert property (p_fall_edge)
		else $error("falling edge did not start downward sweep");

	property p_no_fall;
		active && no_dwell |=> state_r != ddsp_pkg::ST_FALL;
	endproperty
	a_no_fall: assert property (p_no_fall)
		else $error("no-dwell sweep entered downward state");

	property p_nodwell_clear;
		active && no_dwell && state_r == ddsp_pkg::ST_RISE && step && up_done
			|=> acc_r == '0 && state_r == ddsp_pkg::ST_START;
	endproperty
	a_nodwell_clear: assert property (p_nodwell_clear)
		else $error("no-dwell end did not clear accumulator");

	property p_hold_end;
		active && !no_dwell && state_r == ddsp_pkg::ST_END && !p1_rise
			&& !p1_fall |=> $stable(acc_r) && $stable(sweep_busy_r);
	endproperty
	a_hold_end: assert property (p_hold_end)
		else $error("output moved while holding end value");

	property p_step_add;
		active && !no_dwell && state_r == ddsp_pkg::ST_RISE && step
			&& !up_done && !p1_rise && !p1_fall
			|=> acc_r == $past(acc_r) + $past(rdw_al);
	endproperty
	a_step_add: assert property (p_step_add)
		else $error("upward step did not add the step word");

	property p_inactive;
		!active |=> acc_r == '0 && state_r == ddsp_pkg::ST_START
			&& sweep_target_r == ddsp_pkg::TGT_NONE;
	endproperty
	a_inactive: assert property (p_inactive)
		else $error("sweep ran with no valid select");

	property p_sel16;
		level == ddsp_pkg::LVL_16 && pin_assign_config[1:0] == ddsp_pkg::PPC_ANY_01
			|=> profile_index_r == $past({pp[0], pp[1], pp[2], pp[3]});
	endproperty
	a_sel16: assert property (p_sel16)
		else $error("sixteen-level index wrong");

	property p_sel4;
		level == ddsp_pkg::LVL_4 && ramp == ddsp_pkg::RAMP_SDIO
			&& pin_assign_config == ddsp_pkg::PPC_LOW
			|=> profile_index_r == {2'h0, $past(pp[2]), $past(pp[3])}
			&& amplitude_ramp_control_r == $past(pin_s.sdio[2]);
	endproperty
	a_sel4: assert property (p_sel4)
		else $error("four-level index or ramp line wrong");

	property p_ramp_pin;
		ramp == ddsp_pkg::RAMP_P3 |=> amplitude_ramp_control_r
			== !$past(pp[3]) && ramp_enable_r;
	endproperty
	a_ramp_pin: assert property (p_ramp_pin)
		else $error("profile pin ramp polarity wrong");

	c_reach_end: cover property (state_r == ddsp_pkg::ST_RISE
		##1 state_r == ddsp_pkg::ST_END);
	c_back_start: cover property (state_r == ddsp_pkg::ST_FALL
		##1 state_r == ddsp_pkg::ST_START);
	c_nodwell_wrap: cover property (no_dwell && state_r == ddsp_pkg::ST_RISE
		##1 state_r == ddsp_pkg::ST_START);
endmodule : ddsp_top
